// >>> verilog/pulse_tally_cfg.svh
// Purpose: Offsets, reset values, limits and timing counts of the pulse tally.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Definitions only.
`ifndef PULSE_TALLY_CFG_SVH
`define PULSE_TALLY_CFG_SVH

`define OFF_CTRL 8'h00
`define OFF_SCALE 8'h04
`define OFF_PERIOD 8'h08
`define OFF_CMD 8'h0C
`define OFF_TIME 8'h10
`define OFF_STATUS 8'h14
`define OFF_COUNT 8'h18
`define OFF_FROZEN 8'h1C
`define OFF_STAMP 8'h20
`define OFF_SCALED_LO 8'h24
`define OFF_SCALED_HI 8'h28

`define CTRL_OP_BIT 0
`define CTRL_CRIT_LSB 1
`define CMD_READ_BIT 0
`define CMD_GI_BIT 1

`define RST_OP 1'b0
`define RST_CRIT 2'h1
`define RST_SCALE 27'h00003E8
`define SCALE_MIN 27'h00003E8
`define SCALE_MAX 27'h55D4A80
`define RST_PERIOD 12'h03C
`define PERIOD_MAX 12'hE10
`define COUNT_MAX 32'h7FFFFFFF

`define SEC_NS 1000000000
`define CLK_NS 20
`define CLK_PER_SEC (`SEC_NS / `CLK_NS)

`endif

// >>> verilog/pulse_tally_pkg.sv
// Purpose: Types shared by the pulse tally files.
// Assumes: Nothing beyond the configuration header.
// Notes: Scaled values are in thousandths of a unit.
package pulse_tally_pkg;

  typedef enum logic [1:0]
  {
    CRIT_OFF = 2'h0,
    CRIT_RISE = 2'h1,
    CRIT_FALL = 2'h2,
    CRIT_ANY = 2'h3
  } edge_e;

  typedef struct packed
  {
    logic invalid;
    logic wrapped;
    logic blocked;
    logic adjusted;
  } quality_s;

  typedef struct packed
  {
    logic [7:0] id;
    logic [63:0] scaled;
    logic [31:0] stamp;
    quality_s quality;
  } report_s;

endpackage

// >>> verilog/report_clock.sv
// Purpose: Absolute seconds time base and aligned report boundaries.
// Assumes: Software loads the absolute time through time_wr.
// Notes: A boundary falls on each second whose time is a multiple of the period.
`include "pulse_tally_cfg.svh"
module report_clock #(
  parameter int unsigned CYC_PER_SEC = `CLK_PER_SEC
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Time load and period.
  input wire logic time_wr,
  input wire logic [31:0] time_val,
  input wire logic [11:0] period,
  // Time and boundary.
  output logic [31:0] sec_now,
  output logic boundary
);
  localparam int PW = $clog2(CYC_PER_SEC);

  logic [PW-1:0] pre_r;
  logic [31:0] sec_r;
  logic boundary_r;
  wire tick = (pre_r == PW'(CYC_PER_SEC - 1));
  wire [31:0] sec_nxt = sec_r + 32'h00000001;
  // A period of zero switches cyclic reporting off.
  wire aligned = (period != 12'h000) && ((sec_nxt % {20'h00000, period}) == 32'h00000000);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_r <= '0;
      sec_r <= 32'h00000000;
      boundary_r <= 1'b0;
    end
    else
    begin
      pre_r <= (tick || time_wr) ? '0 : pre_r + PW'(1);
      sec_r <= time_wr ? time_val : (tick ? sec_nxt : sec_r);
      boundary_r <= tick && !time_wr && aligned; // RQ2
    end
  end

  assign sec_now = sec_r;
  assign boundary = boundary_r;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  period_align_a: assert property (boundary_r |-> period != 12'h000 && (sec_r % {20'h00000, period}) == 0) // RQ2
    else $error("Report boundary not aligned to the period.");
endmodule

// >>> verilog/pulse_tally_function.sv
// Purpose: Pulse counter with cyclic, on-demand and interrogation reports.
// Assumes: All function inputs are synchronous to pclk.
// Notes: Settings, time and commands are reached over APB.
// Notes on behaviour
// RQ1: Count once per rising transition of the pulse input.
// RQ2: Report cyclically every 1 s to 60 min, aligned to absolute time.
// RQ3: A cyclic report never clears the count.
// RQ4: A command triggers one intermediate reading outside the cycle.
// RQ5: A general interrogation command reports all active counters.
// RQ6: The counter only counts upward and never goes negative.
// RQ7: The count is a 32-bit signed value from zero to the maximum.
// RQ8: Initialization clears the count to zero.
// RQ9: Each report holds identity, scaled value, timestamp and quality.
// RQ10: Quality holds invalid, wrapped, blocked and adjusted indications.
// RQ11: Each cycle end freezes the count, stamps it, pulses fresh value.
// RQ12: No counting while the block input is asserted.
// RQ13: Exactly one extra reading per rising edge of read request.
// RQ14: The driver holds read request high longer than one second.
// RQ15: Count clear input sets the count to zero.
// RQ16: Invalid stays high while the input card fails or is misconfigured.
// RQ17: Partial cycle flag after startup, after unblocking, or after a wrap.
// RQ18: Blocked flag high while blocked or the input card is inoperative.
// RQ19: Fresh value pulses only when the count changed since last report.
// RQ20: Scaled report is count times scale with time and status.
// RQ21: Operation switch off or on, off after reset.
// RQ22: Edge criterion off, rising, falling or any, rising after reset.
// RQ23: Scale 1.000 to 90000.000 in steps of 0.001, default 1.000.
// RQ24: Report period 0 to 3600 s in 1 s steps, default 60 s.
// RQ25: Past the maximum the count wraps to zero and the wrap is recorded.
`include "pulse_tally_cfg.svh"
module pulse_tally_function #(
  parameter int unsigned CYC_PER_SEC = `CLK_PER_SEC,
  // Arbitrary identity value.
  parameter logic [7:0] COUNTER_ID = 8'h01
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Function inputs.
  input wire logic pulse_input,
  input wire logic block,
  input wire logic read_request,
  input wire logic count_clear,
  input wire logic card_fault,
  input wire logic card_down,
  // Function outputs.
  output logic invalid,
  output logic partial_cycle,
  output logic blocked,
  output logic fresh_value_output,
  output pulse_tally_pkg::report_s scaled_report
);
  import pulse_tally_pkg::*;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr[7:2] == off[7:2]);
  endfunction

  function automatic logic edge_hit(input edge_e crit, input logic rise, input logic fall);
    case (crit)
      CRIT_RISE: edge_hit = rise;
      CRIT_FALL: edge_hit = fall;
      CRIT_ANY: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  logic op_r;
  edge_e crit_r;
  logic [26:0] scale_r;
  logic [11:0] period_r;
  logic [31:0] count_r;
  logic [31:0] count_nxt;
  logic pulse_prev_r;
  logic rq_prev_r;
  logic dirty_r;
  logic wrap_r;
  logic adj_r;
  logic unblk_r;
  logic first_r;
  logic invalid_r;
  logic partial_r;
  logic blocked_r;
  logic fresh_r;
  report_s report_r;
  logic [31:0] frozen_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] sec_now;
  logic boundary;

  // Bus decode.
  wire setup = psel && !penable;
  wire wr_go = psel && penable && pready_r && pwrite;
  wire hit_ctrl = hit(paddr, `OFF_CTRL);
  wire hit_scale = hit(paddr, `OFF_SCALE);
  wire hit_period = hit(paddr, `OFF_PERIOD);
  wire hit_cmd = hit(paddr, `OFF_CMD);
  wire hit_time = hit(paddr, `OFF_TIME);
  wire hit_status = hit(paddr, `OFF_STATUS);
  wire hit_count = hit(paddr, `OFF_COUNT);
  wire hit_frozen = hit(paddr, `OFF_FROZEN);
  wire hit_stamp = hit(paddr, `OFF_STAMP);
  wire hit_slo = hit(paddr, `OFF_SCALED_LO);
  wire hit_shi = hit(paddr, `OFF_SCALED_HI);
  wire map_hit = hit_ctrl | hit_scale | hit_period | hit_cmd | hit_time | hit_status |
                 hit_count | hit_frozen | hit_stamp | hit_slo | hit_shi;
  wire time_wr = wr_go && hit_time;
  wire cmd_wr = wr_go && hit_cmd;

  // Out-of-range settings are clamped rather than refused, so a write always lands.
  wire [26:0] scale_in = pwdata[26:0];
  wire scale_big = (pwdata[31:27] != 5'h00) || (scale_in > `SCALE_MAX);
  wire [26:0] scale_wr = scale_big ? `SCALE_MAX : ((scale_in < `SCALE_MIN) ? `SCALE_MIN : scale_in);
  wire [11:0] period_wr = (pwdata[31:12] != 20'h00000 || pwdata[11:0] > `PERIOD_MAX) ?
                          `PERIOD_MAX : pwdata[11:0];

  // Counting.
  wire blk_now = block | card_down;
  wire rise = pulse_input & ~pulse_prev_r;
  wire fall = ~pulse_input & pulse_prev_r;
  wire inc = op_r && !blk_now && edge_hit(crit_r, rise, fall); // RQ1 RQ12 RQ21 RQ22
  wire at_max = (count_r == `COUNT_MAX); // RQ7
  wire wrap_now = inc && at_max;
  wire rq_rise = read_request && !rq_prev_r;
  wire extra_cmd = cmd_wr && (pwdata[`CMD_READ_BIT] || pwdata[`CMD_GI_BIT]);
  // RQ2 RQ4 RQ5 RQ11 RQ13
  wire report_go = op_r && (boundary || rq_rise || extra_cmd);
  wire [63:0] scaled_now = 64'(count_r) * 64'(scale_r);

  // Clear wins over a pulse in the same cycle; a wrap lands on zero.
  always_comb
  begin
    if (count_clear)
      count_nxt = 32'h00000000; // RQ15
    else if (wrap_now)
      count_nxt = 32'h00000000; // RQ25
    else if (inc)
      count_nxt = count_r + 32'h00000001; // RQ6
    else
      count_nxt = count_r; // RQ3
  end

  // Read mux.
  wire [31:0] ctrl_rd = {29'h0, crit_r, op_r};
  wire [31:0] status_rd = {24'h0, report_r.quality, op_r, blocked_r, partial_r, invalid_r};
  wire [31:0] rd_val =
    hit_ctrl ? ctrl_rd :
    hit_scale ? {5'h00, scale_r} :
    hit_period ? {20'h00000, period_r} :
    hit_time ? sec_now :
    hit_status ? status_rd :
    hit_count ? count_r :
    hit_frozen ? frozen_r :
    hit_stamp ? report_r.stamp :
    hit_slo ? report_r.scaled[31:0] :
    hit_shi ? report_r.scaled[63:32] :
    32'h00000000;

  report_clock #(
    .CYC_PER_SEC(CYC_PER_SEC)
  ) u_clock (
    .pclk(pclk),
    .presetn(presetn),
    .time_wr(time_wr),
    .time_val(pwdata),
    .period(period_r),
    .sec_now(sec_now),
    .boundary(boundary)
  );

  // Settings.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_r <= `RST_OP; // RQ21
      crit_r <= edge_e'(`RST_CRIT); // RQ22
      scale_r <= `RST_SCALE; // RQ23
      period_r <= `RST_PERIOD; // RQ24
    end
    else if (wr_go)
    begin
      if (hit_ctrl)
      begin
        op_r <= pwdata[`CTRL_OP_BIT];
        crit_r <= edge_e'(pwdata[`CTRL_CRIT_LSB +: 2]);
      end
      if (hit_scale)
        scale_r <= scale_wr; // RQ23
      if (hit_period)
        period_r <= period_wr; // RQ24
    end
  end

  // Count and per-cycle flags; a new event wins over the report that clears it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_r <= 32'h00000000; // RQ8
      pulse_prev_r <= 1'b0;
      rq_prev_r <= 1'b0;
      dirty_r <= 1'b0;
      wrap_r <= 1'b0;
      adj_r <= 1'b0;
      unblk_r <= 1'b0;
      first_r <= 1'b1;
    end
    else
    begin
      count_r <= count_nxt;
      pulse_prev_r <= pulse_input;
      rq_prev_r <= read_request;
      dirty_r <= inc | count_clear | (dirty_r & ~report_go);
      wrap_r <= wrap_now | (wrap_r & ~report_go); // RQ25
      adj_r <= count_clear | (adj_r & ~report_go);
      unblk_r <= (blocked_r & ~blk_now) | (unblk_r & ~report_go);
      first_r <= first_r & ~report_go;
    end
  end

  // Reports and status outputs.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      invalid_r <= 1'b0;
      partial_r <= 1'b0;
      blocked_r <= 1'b0;
      fresh_r <= 1'b0;
      report_r <= '0;
      frozen_r <= 32'h00000000;
    end
    else
    begin
      invalid_r <= card_fault; // RQ16
      blocked_r <= blk_now; // RQ18
      fresh_r <= report_go & dirty_r; // RQ19
      if (report_go)
      begin
        partial_r <= first_r | unblk_r | wrap_r | wrap_now; // RQ17
        frozen_r <= count_r; // RQ11
        report_r.id <= COUNTER_ID; // RQ9
        report_r.scaled <= scaled_now; // RQ20
        report_r.stamp <= sec_now; // RQ11
        report_r.quality <= '{card_fault, wrap_r | wrap_now, blk_now, adj_r | count_clear}; // RQ10
      end
    end
  end

  // APB answers in the first cycle of the access phase, with no wait state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= setup;
      pslverr_r <= setup && !map_hit;
      if (setup)
        prdata_r <= pwrite ? 32'h00000000 : rd_val;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign invalid = invalid_r;
  assign partial_cycle = partial_r;
  assign blocked = blocked_r;
  assign fresh_value_output = fresh_r;
  assign scaled_report = report_r;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  count_step_a: assert property (inc && !count_clear && !at_max |=> count_r == $past(count_r) + 1) // RQ1
    else $error("Counted edge did not add one.");
  block_hold_a: assert property (blk_now && !count_clear |=> count_r == $past(count_r)) // RQ12
    else $error("Count moved while blocked.");
  clear_zero_a: assert property (count_clear |=> count_r == 32'h00000000) // RQ15
    else $error("Count clear did not zero the count.");
  never_negative_a: assert property (!count_r[31]) // RQ6
    else $error("Count went negative.");
  wrap_record_a: assert property (wrap_now && !count_clear |=> count_r == 0 ##0 wrap_r) // RQ25
    else $error("Wrap not taken or not recorded.");
  fresh_cause_a: assert property (fresh_value_output |-> $past(report_go) && $past(dirty_r)) // RQ19
    else $error("Fresh value without a changed count.");
  invalid_follow_a: assert property (card_fault |=> invalid) // RQ16
    else $error("Invalid not raised for a failed card.");
  blocked_follow_a: assert property ((block || card_down) |=> blocked) // RQ18
    else $error("Blocked flag missing.");
  read_edge_a: assert property (op_r && rq_rise |-> report_go ##1 !rq_rise) // RQ13
    else $error("Read request edge did not report once.");
  scaled_value_a: assert property (report_go |=> scaled_report.scaled == $past(count_r) * $past(scale_r)) // RQ20
    else $error("Scaled value is not count times scale.");
  stamp_freeze_a: assert property (report_go |=> scaled_report.stamp == $past(sec_now)) // RQ11
    else $error("Timestamp is not the freeze instant.");

  // Operation, criterion and count checks, then report contents against the flags of the cycle that the report closes.
  op_off_quiet_a: assert property (!op_r |=> !fresh_value_output) // RQ21
    else $error("Fresh value while operation is off.");
  crit_off_a: assert property (crit_r == CRIT_OFF && !count_clear |=> count_r == $past(count_r)) // RQ22
    else $error("Count moved with the criterion off.");
  report_keep_a: assert property (report_go && !count_clear && !inc |=> count_r == $past(count_r)) // RQ3
    else $error("Report disturbed the count.");
  count_range_a: assert property (count_r <= `COUNT_MAX) // RQ7
    else $error("Count above the largest positive value.");
  partial_first_a: assert property (report_go && first_r |=> partial_cycle) // RQ17
    else $error("First report not marked partial.");
  partial_unblock_a: assert property (report_go && unblk_r |=> partial_cycle) // RQ17
    else $error("Report after unblocking not marked partial.");
  partial_clean_a: assert property (report_go && !first_r && !unblk_r && !wrap_r && !wrap_now |=> !partial_cycle) // RQ17
    else $error("Complete cycle marked partial.");
  quality_invalid_a: assert property (report_go |=> scaled_report.quality.invalid == $past(card_fault)) // RQ10
    else $error("Quality invalid bit wrong.");
  quality_blocked_a: assert property (report_go |=> scaled_report.quality.blocked == $past(blk_now)) // RQ10
    else $error("Quality blocked bit wrong.");
  quality_adjust_a: assert property (report_go && adj_r |=> scaled_report.quality.adjusted) // RQ10
    else $error("Quality adjusted bit missing.");
  report_id_a: assert property (report_go |=> scaled_report.id == COUNTER_ID) // RQ9
    else $error("Report identity wrong.");
  frozen_value_a: assert property (report_go |=> frozen_r == $past(count_r)) // RQ11
    else $error("Frozen value is not the count at the report.");
  report_hold_a: assert property (!report_go |=> $stable(scaled_report)) // RQ11
    else $error("Report changed without a report event.");
  fresh_needed_a: assert property (report_go && dirty_r |=> fresh_value_output) // RQ19
    else $error("Changed count reported without fresh value.");
endmodule

// >>> bench/pulse_meter.sv
// Purpose: Meter model that emits a burst of clean pulses on request.
// Assumes: Pulses are synchronous to pclk; the line rests low between bursts.
// Notes: each level lasts gap plus one cycles, so bursts can be fast or slow.
module pulse_meter
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Burst request.
  input wire logic go,
  input wire logic [3:0] n,
  input wire logic [2:0] gap,
  // Meter line.
  output logic pulse,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] left_r;
  logic [2:0] wait_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pulse <= 1'b0;
      busy <= 1'b0;
      left_r <= 4'h0;
      wait_r <= 3'h0;
    end
    else if (go && !busy)
    begin
      busy <= 1'b1;
      left_r <= n;
      wait_r <= gap;
    end
    else if (busy && wait_r != 3'h0)
      wait_r <= wait_r - 3'h1;
    else if (busy)
    begin
      wait_r <= gap;
      if (pulse)
        left_r <= left_r - 4'h1;
      pulse <= !pulse && left_r != 4'h0;
      busy <= !(pulse && left_r == 4'h1) && left_r != 4'h0;
    end
  end
endmodule

// >>> bench/tb.sv
// Purpose: Self-checking bench for the pulse tally over APB and its function pins.
// Assumes: One second is shortened to CPS cycles.
// Notes: The wrap past the largest count is not reached in a run this short.
`include "pulse_tally_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pulse_tally_pkg::*;
  localparam int unsigned CPS = 10;
  // Arbitrary identity value.
  localparam logic [7:0] CID = 8'h5A;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv, s, tot;
  logic pulse_input, block, read_request, count_clear, card_fault, card_down;
  logic invalid, partial_cycle, blocked, fresh_value_output, go, busy;
  logic [3:0] n;
  logic [2:0] gap;
  report_s scaled_report;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, n_fresh = 0, seed = 84242, k;
  pulse_tally_function #(.CYC_PER_SEC(CPS), .COUNTER_ID(CID)) i_pulse_tally_function (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pulse_input(pulse_input), .block(block),
    .read_request(read_request), .count_clear(count_clear), .card_fault(card_fault), .card_down(card_down),
    .invalid(invalid), .partial_cycle(partial_cycle), .blocked(blocked),
    .fresh_value_output(fresh_value_output), .scaled_report(scaled_report));
  pulse_meter i_pulse_meter (.pclk(pclk), .presetn(presetn), .go(go), .n(n), .gap(gap),
    .pulse(pulse_input), .busy(busy));
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (fresh_value_output === 1'b1)
      n_fresh++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  task print_verdict;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // The request is held until pready is seen high at a rising edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rv = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk({32'h0, rv}, {32'h0, x});
  endtask
  task burst(input int kk, input int g);
    @(posedge pclk);
    n <= kk[3:0];
    gap <= g[2:0];
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    while (busy === 1'b1)
      @(posedge pclk);
    repeat (3) @(posedge pclk);
  endtask
  // Drives count clear, block, card down and card fault together, in that order.
  task pin(input logic [3:0] v);
    @(posedge pclk);
    {count_clear, block, card_down, card_fault} <= v;
    repeat (2) @(posedge pclk);
  endtask
  // Read request stays high past one second so the device never misses it.
  task reading;
    @(posedge pclk);
    n_fresh = 0;
    read_request <= 1'b1;
    repeat (CPS + 2) @(posedge pclk);
    read_request <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  function automatic int exp_count(input logic [1:0] c, input int kk);
    return (c == 2'h0) ? 0 : (c == 2'h3) ? 2 * kk : kk;
  endfunction
  initial
  begin
    {psel, penable, pwrite, block, read_request, count_clear, card_fault, card_down, go} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n = 4'h0;
    gap = 3'h0;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFF_CTRL, 32'h2);
    rd(`OFF_SCALE, 32'h3E8);
    rd(`OFF_PERIOD, 32'h3C);
    rd(`OFF_COUNT, 32'h0);
    apb(1'b0, 8'hFC, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, `OFF_PERIOD, 32'h1388);
    rd(`OFF_PERIOD, 32'hE10);
    apb(1'b1, `OFF_PERIOD, 32'h0);
    apb(1'b1, `OFF_SCALE, 32'h0);
    rd(`OFF_SCALE, 32'h3E8);
    s = 32'h3E8 + ($random(seed) & 32'hFFFF);
    apb(1'b1, `OFF_SCALE, s);
    rd(`OFF_SCALE, s);
    for (int c = 0; c < 5; c++)
    begin
      apb(1'b1, `OFF_CTRL, 32'((((c + 1) % 4) << 1) | 1));
      pin(4'h8);
      pin(4'h0);
      k = 1 + ($random(seed) & 7);
      burst(k, $random(seed) & 3);
      rd(`OFF_COUNT, 32'(exp_count(2'((c + 1) % 4), k)));
    end
    tot = 32'(k);
    apb(1'b1, `OFF_TIME, 32'h3E8);
    reading;
    chk(n_fresh, 1);
    chk(scaled_report.scaled, 64'(tot) * 64'(s));
    chk(scaled_report.id, CID);
    chk(scaled_report.stamp, 32'h3E8);
    chk(partial_cycle, 1'b1);
    chk(scaled_report.quality.adjusted, 1'b1);
    rd(`OFF_FROZEN, tot);
    reading;
    chk(n_fresh, 0);
    chk(scaled_report.quality.adjusted, 1'b0);
    pin(4'h4);
    burst(5, 0);
    rd(`OFF_COUNT, tot);
    chk(blocked, 1'b1);
    apb(1'b1, `OFF_CMD, 32'h1);
    @(posedge pclk);
    chk(scaled_report.quality.blocked, 1'b1);
    pin(4'h0);
    pin(4'h2);
    chk(blocked, 1'b1);
    pin(4'h0);
    pin(4'h1);
    chk({blocked, invalid}, 2'b01);
    apb(1'b1, `OFF_CMD, 32'h1);
    @(posedge pclk);
    chk({scaled_report.quality.invalid, scaled_report.quality.blocked, partial_cycle}, 3'b101);
    pin(4'h0);
    k = 1 + ($random(seed) & 7);
    burst(k, 2);
    tot = tot + 32'(k);
    reading;
    chk(partial_cycle, 1'b0);
    chk(scaled_report.scaled, 64'(tot) * 64'(s));
    for (int b = 1; b < 3; b++)
    begin
      burst(1, 0);
      tot = tot + 32'h1;
      n_fresh = 0;
      apb(1'b1, `OFF_CMD, 32'(b));
      repeat (3) @(posedge pclk);
      chk(n_fresh, 1);
      rd(`OFF_FROZEN, tot);
    end
    apb(1'b1, `OFF_PERIOD, 32'h2);
    repeat (5 * CPS) @(posedge pclk);
    n_fresh = 0;
    burst(1, 0);
    tot = tot + 32'h1;
    repeat (5 * CPS) @(posedge pclk);
    chk(n_fresh, 1);
    chk(scaled_report.stamp[0], 1'b0);
    chk(scaled_report.scaled, 64'(tot) * 64'(s));
    rd(`OFF_COUNT, tot);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFF_COUNT, 32'h0);
    rd(`OFF_CTRL, 32'h2);
    print_verdict();
  end
endmodule
